// ### core/pmw_pkg.sv
// Constants for the power mode and wake-up controller.
// Assumes a single 20 MHz clock and an 8-bit register port.
package pmw_pkg;
   localparam int unsigned DW = 8;
   localparam int unsigned AW = 8;
   localparam int unsigned PA_N = 8;
   localparam int unsigned INT_N = 8;

   // Register offsets
   localparam logic [7:0] OFS_SYSCLK = 8'h00;
   localparam logic [7:0] OFS_HSCTL = 8'h01;
   localparam logic [7:0] OFS_XTCTL = 8'h02;
   localparam logic [7:0] OFS_PAWAKE = 8'h03;
   localparam logic [7:0] OFS_STATUS = 8'h04;

   // Field positions
   localparam int unsigned SC_CKS_LO = 5;
   localparam int unsigned SC_FSS = 2;
   localparam int unsigned SC_HKEEP = 1;
   localparam int unsigned SC_LKEEP = 0;
   localparam int unsigned HS_FREQ_LO = 2;
   localparam int unsigned HS_FLAG = 1;
   localparam int unsigned HS_EN = 0;
   localparam int unsigned XT_SPEED = 2;
   localparam int unsigned XT_FLAG = 1;
   localparam int unsigned XT_EN = 0;
   localparam int unsigned ST_PDF = 0;
   localparam int unsigned ST_TO = 1;
   localparam int unsigned ST_MODE_LO = 2;
   localparam int unsigned ST_SWITCH = 5;

   // Reset values and the sub clock select code
   localparam logic [2:0] CKS_RST = 3'h0;
   localparam logic [1:0] HS_FREQ_RST = 2'h0;
   localparam logic HS_EN_RST = 1'b1;
   localparam logic [2:0] CKS_SUB = 3'h7;

   // Timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned HS_START_NS = 16000;
   localparam int unsigned XT_FAST_NS = 100000;
   localparam int unsigned XT_SLOW_NS = 1000000;
   localparam int unsigned HS_START_CYC =
      (HS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned XT_FAST_CYC =
      (XT_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned XT_SLOW_CYC =
      (XT_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] SW_GAP_CYC = 3'h4;

   typedef enum logic [2:0] {
      PW_RUN = 3'b000,
      PW_SLEEP = 3'b001,
      PW_IDLE_SUB_CLOCK_ONLY = 3'b010,
      PW_IDLE_BOTH_CLOCKS = 3'b011,
      PW_IDLE_HIGH_CLOCK_ONLY = 3'b100
   } pmw_pwr_t;

   typedef enum logic [1:0] {
      CK_RUN = 2'b00,
      CK_GATE = 2'b01,
      CK_SWAP = 2'b10
   } pmw_ck_t;
endpackage

// ### core/pmw_ctrl.sv
// Operating mode, oscillator and wake-up controller.
// Assumes CPU strobes and interrupt flags on clk; port A pins are
// asynchronous. Oscillators report back only through the counters here.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps

// Contract
// [R1] Speed-up bit selects fast crystal start
// [R2] Speed-up write ignored while crystal clocks system
// [R3] Crystal enable clears then sets stable flag
// [R4] Crystal enable bit; bits 7..3 read zero
// [R5] Select 111 switches system to sub clock
// [R6] Slow switch waits for chosen sub oscillator
// [R7] Select 000..110 gives high clock divided
// [R8] Fast return waits for high oscillator restart
// [R9] Halt with keep 00 enters sleep
// [R10] Halt with keep 01 enters idle_sub_clock_only
// [R11] Halt with keep 11 enters idle_both_clocks
// [R12] Halt with keep 10 enters idle_high_clock_only
// [R13] Halt stops execution, state is retained
// [R14] Halt sets power-down, clears timeout and watchdog
// [R15] Wake on port edge, interrupt, watchdog
// [R16] Power-down cleared by power-up or clear-watchdog
// [R17] Watchdog wake sets timeout, resets PC/SP
// [R18] Enabled port A falling edge resumes after halt
// [R19] Disabled or stack-full interrupt resumes after halt
// [R20] Enabled interrupt with room takes normal response
// [R21] Flag set before halt cannot wake
// [R22] Sub select 0 internal, 1 crystal
// [R23] High oscillator restart clears then sets flag
// [R24] Clock source changes are glitch free
module pmw_ctrl
   import pmw_pkg::*;
#(
   parameter int unsigned XT_SLOW_CYCLES = XT_SLOW_CYC
) (
   input wire logic clk, // 20 MHz clock
   input wire logic rst, // Async reset, high
   input wire logic [AW-1:0] addr, // Register address
   input wire logic [DW-1:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [DW-1:0] rdata, // Read data, cycle after rd
   input wire logic halt_exec, // Halt instruction executed
   input wire logic clr_wdt, // Clear-watchdog instruction
   input wire logic wdt_overflow, // Watchdog overflow pulse
   input wire logic [PA_N-1:0] port_a, // Port A pins, async
   input wire logic [INT_N-1:0] int_req, // Interrupt request flags
   input wire logic [INT_N-1:0] int_enable, // Interrupt enables
   input wire logic stack_full, // Stack has no free level
   output logic cpu_run, // Program execution allowed
   output logic [2:0] sys_clk_sel, // Applied divider or sub select
   output logic sys_clk_sub, // Applied sub source, 1 crystal
   output logic sys_clk_on, // System clock gate
   output logic hs_osc_on, // High speed oscillator enable
   output logic [1:0] hs_freq_sel, // Applied high speed frequency
   output logic xt_osc_on, // Crystal oscillator enable
   output logic xt_speed_up, // Crystal fast start mode
   output logic sub_clk_on, // Sub clock to peripherals
   output logic [2:0] pwr_mode, // Current power mode
   output logic wdt_clear, // Clear watchdog counter pulse
   output logic pc_sp_reset, // Reset PC and SP pulse
   output logic int_response, // Take interrupt on wake pulse
   output logic resume_next // Resume after halt pulse
);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   pmw_pwr_t pstate, next_pstate;
   pmw_ck_t ck_state, next_ck_state;

   logic [2:0] clk_select;
   logic sub_select, hs_keep, ls_keep;
   logic [1:0] hs_freq;
   logic hs_en, hs_flag;
   logic [15:0] hs_cnt;
   logic xt_en, xt_flag;
   logic [15:0] xt_cnt;
   logic [PA_N-1:0] wake_mask;
   logic power_down_flag, watchdog_timeout_flag;
   logic [PA_N-1:0] pa_meta, pa_sync, pa_last;
   logic [INT_N-1:0] int_masked;
   logic [2:0] gap_cnt;

   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Register decode
   wire wr_sc = wr && hit(addr, OFS_SYSCLK);
   wire wr_hs = wr && hit(addr, OFS_HSCTL);
   wire wr_xt = wr && hit(addr, OFS_XTCTL);
   wire wr_pa = wr && hit(addr, OFS_PAWAKE);
   wire halted = (pstate != PW_RUN);
   wire halt_take = halt_exec && !halted;
   wire xt_locked = (clk_select == CKS_SUB) && sub_select;
   wire hs_freq_chg = wr_hs && (wdata[HS_FREQ_LO +: 2] != hs_freq);

   wire [DW-1:0] rd_sc = {clk_select, 2'b00, sub_select, hs_keep, ls_keep};
   wire [DW-1:0] rd_hs = {4'h0, hs_freq, hs_flag, hs_en};
   wire [DW-1:0] rd_xt = {5'h00, xt_speed_up, xt_flag, xt_en}; // R4
   wire [DW-1:0] rd_st = {2'b00, ck_state != CK_RUN, pstate,
                          watchdog_timeout_flag, power_down_flag};
   wire [DW-1:0] rd_mux =
      hit(addr, OFS_SYSCLK) ? rd_sc :
      hit(addr, OFS_HSCTL) ? rd_hs :
      hit(addr, OFS_XTCTL) ? rd_xt :
      hit(addr, OFS_PAWAKE) ? wake_mask :
      hit(addr, OFS_STATUS) ? rd_st : 8'h00;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_select <= CKS_RST;
         sub_select <= 1'b0;
         hs_keep <= 1'b0;
         ls_keep <= 1'b0;
         hs_freq <= HS_FREQ_RST;
         hs_en <= HS_EN_RST;
         xt_en <= 1'b0;
         xt_speed_up <= 1'b0;
         wake_mask <= 8'h00;
         rdata <= 8'h00;
      end else begin
         if (wr_sc) begin
            clk_select <= wdata[SC_CKS_LO +: 3]; // R5 R7
            sub_select <= wdata[SC_FSS]; // R22
            hs_keep <= wdata[SC_HKEEP];
            ls_keep <= wdata[SC_LKEEP];
         end
         if (wr_hs) begin
            hs_freq <= wdata[HS_FREQ_LO +: 2];
            hs_en <= wdata[HS_EN];
         end
         if (wr_xt) begin
            xt_en <= wdata[XT_EN]; // R4
            if (!xt_locked) begin
               xt_speed_up <= wdata[XT_SPEED]; // R1 R2
            end
         end
         if (wr_pa) begin
            wake_mask <= wdata; // R18
         end
         rdata <= rd ? rd_mux : 8'h00;
      end
   end

   lock_speed_a: assert property ( // R2
      wr_xt && xt_locked |=> $stable(xt_speed_up))
      else $error("speed-up changed while crystal clocks system");

   // High speed oscillator: needed while running in fast mode or when enabled; while halted only when kept on
   wire hs_want = halted ? hs_keep :
      (hs_en || clk_select != CKS_SUB || sys_clk_sel != CKS_SUB);
   wire hs_restart = hs_want && (!hs_osc_on || hs_freq_chg);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hs_osc_on <= 1'b0;
         hs_flag <= 1'b0;
         hs_cnt <= 16'h0000;
         hs_freq_sel <= HS_FREQ_RST;
      end else begin
         hs_osc_on <= hs_want;
         if (!hs_want || hs_restart) begin
            hs_flag <= 1'b0; // R23 R8
            hs_cnt <= 16'h0000;
         end else if (!hs_flag) begin
            hs_cnt <= hs_cnt + 16'h0001;
            if (hs_cnt == 16'(HS_START_CYC - 1)) begin
               hs_flag <= 1'b1; // R23
               hs_freq_sel <= hs_freq;
            end
         end
      end
   end

   hs_restart_a: assert property ( // R23
      hs_freq_chg && hs_want |=> !hs_flag ##1 !hs_flag)
      else $error("high speed flag not cleared on frequency change");

   // Crystal: stops in sleep and idle_high_clock_only where the sub clock is off
   wire xt_want = xt_en && !(halted && !ls_keep);
   wire [15:0] xt_last = xt_speed_up ? 16'(XT_FAST_CYC - 1) :
                         16'(XT_SLOW_CYCLES - 1); // R1

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xt_osc_on <= 1'b0;
         xt_flag <= 1'b0;
         xt_cnt <= 16'h0000;
      end else begin
         xt_osc_on <= xt_want;
         if (!xt_want || !xt_osc_on) begin
            xt_flag <= 1'b0; // R3
            xt_cnt <= 16'h0000;
         end else if (!xt_flag) begin
            xt_cnt <= xt_cnt + 16'h0001;
            if (xt_cnt >= xt_last) begin
               xt_flag <= 1'b1; // R3
            end
         end
      end
   end

   xt_restart_a: assert property ( // R3
      wr_xt && wdata[XT_EN] && !xt_en && !halted |=> ##1 !xt_flag)
      else $error("crystal flag not cleared on enable");

   // System clock switch: gate, wait for target stable, swap, ungate
   wire sub_ok = sub_select ? xt_flag : 1'b1; // R6 R22
   wire to_sub = (clk_select == CKS_SUB);
   wire tgt_ok = to_sub ? sub_ok : hs_flag; // R6 R8
   wire mismatch = (clk_select != sys_clk_sel) ||
                   (to_sub && sub_select != sys_clk_sub);

   always_comb begin
      next_ck_state = ck_state;
      case (ck_state)
         CK_RUN: begin
            if (mismatch && !halted) begin
               next_ck_state = CK_GATE; // R24
            end
         end
         CK_GATE: begin
            if (gap_cnt >= SW_GAP_CYC - 3'h1 && tgt_ok) begin
               next_ck_state = CK_SWAP;
            end
         end
         CK_SWAP: next_ck_state = CK_RUN;
         default: next_ck_state = CK_RUN;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ck_state <= CK_RUN;
         gap_cnt <= 3'h0;
         sys_clk_sel <= CKS_RST;
         sys_clk_sub <= 1'b0;
         sys_clk_on <= 1'b0;
      end else begin
         ck_state <= next_ck_state;
         gap_cnt <= (ck_state == CK_GATE) ? gap_cnt + 3'h1 : 3'h0;
         if (ck_state == CK_GATE && next_ck_state == CK_SWAP) begin
            sys_clk_sel <= clk_select; // R5 R7
            sys_clk_sub <= sub_select;
         end
         sys_clk_on <= (ck_state == CK_RUN) && !mismatch &&
                       (next_pstate == PW_RUN); // R24 R13
      end
   end

   glitch_free_a: assert property ( // R24
      $changed(sys_clk_sel) || $changed(sys_clk_sub) |->
         !sys_clk_on && $past(!sys_clk_on))
      else $error("clock source changed while clock enabled");

   slow_wait_a: assert property ( // R6
      $changed(sys_clk_sel) && sys_clk_sel == CKS_SUB |->
         $past(sub_ok))
      else $error("slow mode entered before sub clock stable");

   fast_wait_a: assert property ( // R8
      $changed(sys_clk_sel) && $past(sys_clk_sel) == CKS_SUB |->
         $past(hs_flag))
      else $error("fast mode entered before high clock stable");

   // Port A falling edge, two flops before the edge detector
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pa_meta <= 8'hff;
         pa_sync <= 8'hff;
         pa_last <= 8'hff;
      end else begin
         pa_meta <= port_a;
         pa_sync <= pa_meta;
         pa_last <= pa_sync;
      end
   end

   wire pa_wake = |(pa_last & ~pa_sync & wake_mask); // R18
   wire [INT_N-1:0] int_new = int_req & ~int_masked; // R21
   wire int_wake = |int_new;
   wire int_serve = |(int_new & int_enable) && !stack_full; // R19 R20
   wire wake = halted && (wdt_overflow || int_wake || pa_wake); // R15

   always_comb begin
      next_pstate = pstate;
      case (pstate)
         PW_RUN: begin
            if (halt_take) begin
               case ({hs_keep, ls_keep})
                  2'b00: next_pstate = PW_SLEEP; // R9
                  2'b01: next_pstate = PW_IDLE_SUB_CLOCK_ONLY; // R10
                  2'b11: next_pstate = PW_IDLE_BOTH_CLOCKS; // R11
                  default: next_pstate = PW_IDLE_HIGH_CLOCK_ONLY; // R12
               endcase
            end
         end
         PW_SLEEP, PW_IDLE_SUB_CLOCK_ONLY, PW_IDLE_BOTH_CLOCKS, PW_IDLE_HIGH_CLOCK_ONLY: begin
            if (wake) begin
               next_pstate = PW_RUN; // R15
            end
         end
         default: next_pstate = PW_RUN;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pstate <= PW_RUN;
         pwr_mode <= PW_RUN;
         cpu_run <= 1'b0;
         sub_clk_on <= 1'b0;
         int_masked <= 8'h00;
      end else begin
         pstate <= next_pstate;
         pwr_mode <= next_pstate;
         cpu_run <= (next_pstate == PW_RUN); // R13
         sub_clk_on <= (next_pstate == PW_RUN) ||
                       (next_pstate == PW_IDLE_SUB_CLOCK_ONLY) ||
                       (next_pstate == PW_IDLE_BOTH_CLOCKS); // R9 R10 R11 R12
         int_masked <= halt_take ? int_req : (int_masked & int_req); // R21
      end
   end

   sleep_entry_a: assert property ( // R9
      halt_take && !hs_keep && !ls_keep |=>
         pwr_mode == PW_SLEEP && !cpu_run ##1 !sub_clk_on && !hs_osc_on)
      else $error("sleep entry wrong");

   idle_both_clocks_keep_a: assert property ( // R11
      pstate == PW_IDLE_BOTH_CLOCKS |-> sub_clk_on && !cpu_run ##1 hs_osc_on)
      else $error("idle_both_clocks lost a clock");

   idle_high_clock_only_keep_a: assert property ( // R12
      pstate == PW_IDLE_HIGH_CLOCK_ONLY && $past(pstate == PW_IDLE_HIGH_CLOCK_ONLY) |->
         hs_osc_on && !sub_clk_on && !xt_osc_on)
      else $error("idle_high_clock_only clock state wrong");

   idle_sub_clock_only_keep_a: assert property ( // R10
      pstate == PW_IDLE_SUB_CLOCK_ONLY && $past(pstate == PW_IDLE_SUB_CLOCK_ONLY) |->
         sub_clk_on && !hs_osc_on)
      else $error("idle_sub_clock_only clock state wrong");

   old_int_a: assert property ( // R21
      halted && !wdt_overflow && !pa_wake && int_new == 8'h00 |=>
         !cpu_run)
      else $error("pre-halt interrupt woke the device");

   // Status flags and wake-up pulses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_down_flag <= 1'b0;
         watchdog_timeout_flag <= 1'b0;
         wdt_clear <= 1'b0;
         pc_sp_reset <= 1'b0;
         int_response <= 1'b0;
         resume_next <= 1'b0;
      end else begin
         if (halt_take) begin
            power_down_flag <= 1'b1; // R14
         end else if (clr_wdt) begin
            power_down_flag <= 1'b0; // R16
         end
         if (wdt_overflow) begin
            watchdog_timeout_flag <= 1'b1; // R17
         end else if (halt_take) begin
            watchdog_timeout_flag <= 1'b0; // R14
         end
         wdt_clear <= halt_take || clr_wdt; // R14
         pc_sp_reset <= wake && wdt_overflow; // R17
         int_response <= wake && !wdt_overflow && int_serve; // R20
         resume_next <= wake && !wdt_overflow && !int_serve; // R18 R19
      end
   end

   halt_flags_a: assert property ( // R14
      halt_take && !wdt_overflow |=>
         power_down_flag && !watchdog_timeout_flag && wdt_clear)
      else $error("halt entry flags wrong");

   pdf_hold_a: assert property ( // R16
      power_down_flag && !clr_wdt |=> power_down_flag)
      else $error("power-down flag dropped without clear");

   wdt_wake_a: assert property ( // R17
      halted && wdt_overflow |=>
         pc_sp_reset && watchdog_timeout_flag && cpu_run &&
         !int_response && !resume_next)
      else $error("watchdog wake-up wrong");

   pin_wake_a: assert property ( // R18
      halted && pa_wake && !wdt_overflow && !int_wake |=>
         resume_next && cpu_run)
      else $error("port wake-up did not resume");

   int_wake_a: assert property ( // R20
      halted && int_wake && !wdt_overflow |=>
         (int_response == $past(int_serve)) && cpu_run)
      else $error("interrupt wake-up response wrong");

endmodule

// ### tb/pmw_ctrl_tb.sv
// Self-checking bench for the power mode and wake-up controller.
// Drives the register port and CPU event pins itself; no far-side model.
`timescale 1ns/1ps
module pmw_ctrl_tb;
   import pmw_pkg::*;
   // Short crystal start keeps the run brief
   localparam int unsigned XT_SIM = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [AW-1:0] addr = '0;
   logic [DW-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic halt_exec = 1'b0;
   logic clr_wdt = 1'b0;
   logic wdt_overflow = 1'b0;
   logic [PA_N-1:0] port_a = '1;
   logic [INT_N-1:0] int_req = '0;
   logic [INT_N-1:0] int_enable = '0;
   logic stack_full = 1'b0;
   logic [DW-1:0] rdata;
   logic cpu_run, sys_clk_sub, sys_clk_on, hs_osc_on, xt_osc_on;
   logic xt_speed_up, sub_clk_on, wdt_clear, pc_sp_reset;
   logic int_response, resume_next;
   logic [2:0] sys_clk_sel, pwr_mode;
   logic [1:0] hs_freq_sel;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int n;
   int k;
   logic [2:0] pin, a, s;
   logic [2:0] last_sel = 3'h0;
   logic last_on = 1'b0;

   pmw_ctrl #(.XT_SLOW_CYCLES(XT_SIM)) u_dut (.clk(clk), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .halt_exec(halt_exec), .clr_wdt(clr_wdt), .wdt_overflow(wdt_overflow),
      .port_a(port_a), .int_req(int_req), .int_enable(int_enable),
      .stack_full(stack_full), .cpu_run(cpu_run), .sys_clk_sel(sys_clk_sel),
      .sys_clk_sub(sys_clk_sub), .sys_clk_on(sys_clk_on),
      .hs_osc_on(hs_osc_on), .hs_freq_sel(hs_freq_sel),
      .xt_osc_on(xt_osc_on), .xt_speed_up(xt_speed_up),
      .sub_clk_on(sub_clk_on), .pwr_mode(pwr_mode), .wdt_clear(wdt_clear),
      .pc_sp_reset(pc_sp_reset), .int_response(int_response),
      .resume_next(resume_next));

   always #25 clk = ~clk;

   task automatic print_verdict();
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rchk(input string what, input logic [7:0] ad,
                       input logic [7:0] mask, input logic [7:0] exp);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(what, rdata & mask, exp);
   endtask

   // Waits for the applied select, returns how long the switch took
   task automatic wait_clk(input logic [2:0] sel, input logic sub,
                           output int cnt);
      for (cnt = 0; cnt < 2500; cnt++) begin
         if (sys_clk_sel === sel && (sel != 3'h7 || sys_clk_sub === sub))
            break;
         @(posedge clk);
         #1;
      end
      check("sys_clk_sel", 8'(sys_clk_sel), 8'(sel));
      if (sel == 3'h7)
         check("sys_clk_sub", 8'(sys_clk_sub), 8'(sub));
      repeat (3) @(posedge clk);
      #1;
      check("sys_clk_on", 8'(sys_clk_on), 8'h01);
   endtask

   // Mode that a halt must enter for the two keep bits
   function automatic logic [2:0] exp_mode(input logic [1:0] keep);
      case (keep)
         2'b00: exp_mode = PW_SLEEP;
         2'b01: exp_mode = PW_IDLE_SUB_CLOCK_ONLY;
         2'b11: exp_mode = PW_IDLE_BOTH_CLOCKS;
         default: exp_mode = PW_IDLE_HIGH_CLOCK_ONLY;
      endcase
   endfunction

   task automatic do_halt(input logic [1:0] keep);
      reg_wr(OFS_SYSCLK, {3'h3, 2'h0, 1'b1, keep});
      @(posedge clk);
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      #1;
      check("pwr_mode", 8'(pwr_mode), 8'(exp_mode(keep)));
      check("cpu_run", 8'(cpu_run), 8'h00);
      check("wdt_clear", 8'(wdt_clear), 8'h01);
      @(posedge clk);
      #1;
      check("sub_clk_on", 8'(sub_clk_on), 8'(keep[0]));
      check("hs_osc_on", 8'(hs_osc_on), 8'(keep[1]));
   endtask

   task automatic wake_chk(input logic [2:0] pulses, input logic to_exp);
      int i;
      #1;
      for (i = 0; i < 12 && cpu_run !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      check("cpu_run", 8'(cpu_run), 8'h01);
      check("wake pulses", 8'({pc_sp_reset, int_response, resume_next}),
            8'(pulses));
      check("pwr_mode", 8'(pwr_mode), 8'h00);
      rchk("status", OFS_STATUS, 8'h03, {6'h0, to_exp, 1'b1});
   endtask

   // A select change must only land while the system clock is gated
   always @(posedge clk) begin
      if (!rst && sys_clk_sel !== last_sel)
         check("gate at swap", 8'({last_on, sys_clk_on}), 8'h00);
      last_sel <= sys_clk_sel;
      last_on <= sys_clk_on;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   initial begin
      void'($urandom(32'he1a3));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rchk("crystal ctl", OFS_XTCTL, 8'hff, 8'h00);
      rchk("sysclk ctl", OFS_SYSCLK, 8'hff, 8'h00);
      rchk("unmapped", 8'h3c, 8'hff, 8'h00);
      rchk("hs ctl", OFS_HSCTL, 8'hff, 8'h01);
      repeat (HS_START_CYC + 10) @(posedge clk);
      rchk("hs ctl", OFS_HSCTL, 8'hff, 8'h03);
      reg_wr(OFS_HSCTL, 8'h05);
      rchk("hs ctl", OFS_HSCTL, 8'hff, 8'h05);
      check("hs_freq_sel", 8'(hs_freq_sel), 8'h00);
      repeat (HS_START_CYC + 10) @(posedge clk);
      rchk("hs ctl", OFS_HSCTL, 8'hff, 8'h07);
      check("hs_freq_sel", 8'(hs_freq_sel), 8'h01);
      reg_wr(OFS_XTCTL, 8'h01);
      rchk("crystal ctl", OFS_XTCTL, 8'hff, 8'h01);
      check("xt_osc_on", 8'(xt_osc_on), 8'h01);
      check("xt_speed_up", 8'(xt_speed_up), 8'h00);
      repeat (XT_SIM + 10) @(posedge clk);
      rchk("crystal ctl", OFS_XTCTL, 8'hff, 8'h03);
      reg_wr(OFS_XTCTL, 8'hff);
      rchk("crystal ctl", OFS_XTCTL, 8'hf8, 8'h00);
      check("xt_speed_up", 8'(xt_speed_up), 8'h01);
      for (k = 0; k < 3; k++) begin
         s = 3'($urandom_range(0, 6));
         reg_wr(OFS_SYSCLK, {s, 5'h00});
         wait_clk(s, 1'b0, n);
      end
      reg_wr(OFS_SYSCLK, 8'he0);
      wait_clk(3'h7, 1'b0, n);
      s = 3'($urandom_range(0, 6));
      reg_wr(OFS_SYSCLK, {s, 5'h00});
      wait_clk(s, 1'b0, n);
      reg_wr(OFS_SYSCLK, 8'he4);
      wait_clk(3'h7, 1'b1, n);
      reg_wr(OFS_XTCTL, 8'h01);
      check("xt_speed_up", 8'(xt_speed_up), 8'h01);
      reg_wr(OFS_HSCTL, 8'h04);
      reg_wr(OFS_SYSCLK, 8'h64);
      reg_wr(OFS_HSCTL, 8'h05);
      wait_clk(3'h3, 1'b1, n);
      check("hs restart wait", 8'(n > 300), 8'h01);
      rchk("hs ctl", OFS_HSCTL, 8'hff, 8'h07);
      reg_wr(OFS_XTCTL, 8'h01);
      check("xt_speed_up", 8'(xt_speed_up), 8'h00);
      // Sleep, woken by the watchdog
      do_halt(2'b00);
      @(posedge clk);
      wdt_overflow <= 1'b1;
      @(posedge clk);
      wdt_overflow <= 1'b0;
      wake_chk(3'b100, 1'b1);
      // Idle_sub_clock_only, an edge on a disabled pin first, then on the enabled one
      pin = 3'($urandom_range(0, 7));
      reg_wr(OFS_PAWAKE, 8'h01 << pin);
      do_halt(2'b01);
      @(posedge clk);
      port_a[pin + 3'h1] <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check("cpu_run", 8'(cpu_run), 8'h00);
      @(posedge clk);
      port_a[pin] <= 1'b0;
      wake_chk(3'b001, 1'b0);
      @(posedge clk);
      port_a <= '1;
      // Idle_both_clocks, enabled interrupt with stack room
      a = 3'($urandom_range(0, 7));
      do_halt(2'b11);
      @(posedge clk);
      int_enable <= 8'h01 << a;
      int_req <= 8'h01 << a;
      wake_chk(3'b010, 1'b0);
      // Idle_high_clock_only, a flag already up at halt must not wake
      @(posedge clk);
      int_req <= 8'h01 << a;
      do_halt(2'b10);
      repeat (8) @(posedge clk);
      #1;
      check("cpu_run", 8'(cpu_run), 8'h00);
      @(posedge clk);
      // Either a full stack or a disabled interrupt must only resume
      s[0] = 1'($urandom_range(0, 1));
      stack_full <= s[0];
      int_enable <= s[0] ? 8'hff : 8'h00;
      int_req <= (8'h01 << a) | (8'h01 << (a + 3'h1));
      wake_chk(3'b001, 1'b0);
      @(posedge clk);
      int_req <= '0;
      clr_wdt <= 1'b1;
      @(posedge clk);
      clr_wdt <= 1'b0;
      #1;
      check("wdt_clear", 8'(wdt_clear), 8'h01);
      rchk("status", OFS_STATUS, 8'h01, 8'h00);
      print_verdict();
   end
endmodule
